// File: design/sdo_pkg.sv
// Purpose: Shared constants for the SDRAM pin override and refresh check block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Printed offsets are not all multiples of four, so they are indices

package sdo_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [11:0] IDX_CTRL = 12'h0250;
   localparam logic [11:0] IDX_REFRESH_CNT = 12'h0252;
   localparam logic [11:0] IDX_LATE_LIMIT = 12'h0254;
   localparam logic [11:0] IDX_IDLE_ADDR = 12'h0256;
   localparam logic [11:0] IDX_MAN_ADDR = 12'h0258;
   localparam logic [11:0] IDX_CMD_LEVELS = 12'h025a;
   localparam logic [11:0] IDX_LATE_STAT = 12'h025c;
   localparam logic [11:0] IDX_INT_MASK = 12'h025e;

   // Reset values
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [15:0] RST_REFRESH_CNT = 16'h0400;
   localparam logic [15:0] RST_LATE_LIMIT = 16'h0200;
   localparam logic [15:0] RST_IDLE_ADDR = 16'h0000;
   localparam logic [15:0] RST_MAN_ADDR = 16'h0000;
   localparam logic [15:0] RST_CMD_LEVELS = 16'h003f;

   // Control register fields
   localparam int CTRL_EN_A = 0;
   localparam int CTRL_EN_B = 1;
   localparam int CTRL_MAN_A = 2;
   localparam int CTRL_MAN_B = 3;

   // Command line level fields
   localparam int CMD_CAS_IDLE = 0;
   localparam int CMD_RAS_IDLE = 1;
   localparam int CMD_WE_IDLE = 2;
   localparam int CMD_CAS_MAN = 3;
   localparam int CMD_RAS_MAN = 4;
   localparam int CMD_WE_MAN = 5;

   // Address field width and status bits
   localparam int ADDR_W = 14;
   localparam int STAT_LATE_A = 0;
   localparam int STAT_LATE_B = 1;

   // Pin override mode
   typedef enum logic [1:0] {
      SDO_NORMAL,
      SDO_IDLE,
      SDO_MANUAL
   } sdo_mode_t;

endpackage

// File: design/sdo_refresh_check.sv
// Purpose: Per-bank refresh schedule and lateness check
// Assumes: refresh_done pulses once per refresh actually issued
// Notes: Owed count saturates; error pulses when it first exceeds the limit

`timescale 1ns/10ps
`default_nettype none

module sdo_refresh_check #(
   parameter int CW = 16
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic run,
   input wire logic [CW-1:0] interval,
   input wire logic [CW-1:0] limit,
   input wire logic refresh_done,
   output logic refresh_req,
   output logic late_error
);
   logic [CW-1:0] tick; // Cycles since last scheduled refresh
   logic [CW-1:0] owed; // Refreshes behind schedule
   logic over; // Already reported
   wire due = run && (tick >= interval - CW'(1)); // Schedule point
   wire [CW-1:0] next_owed = (due && !refresh_done && owed != '1) ? owed + CW'(1) :
                             (!due && refresh_done && owed != '0) ? owed - CW'(1) : owed;
   wire next_over = next_owed > limit;

   assign refresh_req = owed != '0;

   // Schedule counter and lateness tracking
   // Counter wraps at the interval, one refresh owed per wrap
   // A done pulse on the same cycle cancels the new debt
   // Owed count saturates so it never wraps to zero
   always_ff @(posedge mclk) begin
      if (!rstn || !run) begin
         tick <= '0;
         owed <= '0;
         over <= 1'b0;
         late_error <= 1'b0;
      end else begin
         tick <= due ? '0 : tick + CW'(1);
         owed <= next_owed;
         over <= next_over;
         late_error <= next_over && !over;
      end
   end
endmodule

`default_nettype wire

// File: design/sdo_top.sv
// Purpose: SDRAM pin override and refresh lateness check with APB registers
// Assumes: APB slave, zero wait states; normal scheduler drives the *_ctl inputs
// Notes: Lateness events set sticky status, cleared by reading it
// Operation
// - 16-bit lateness limit, reset 0x0200, errors beyond
// - Disabled bank drives idle address value
// - Manual pulse drives manual address one cycle
// - Disabled bank drives CAS RAS WE idle bits
// - Manual pulse drives CAS RAS WE manual bits
// - Enable bits 0 and 1 for banks A, B
// - Self-clearing pulse bits 2 and 3 per bank
// - Refresh interval count, reset 0x0400
//
// Implementation choice: the APB register port.

`timescale 1ns/10ps
`default_nettype none

module sdo_top
   import sdo_pkg::*;
#(
   parameter int AW = sdo_pkg::ADDR_W
) (
   input wire logic mclk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Normal controller pins, bank A and B
   input wire logic [AW-1:0] ctl_addr_a,
   input wire logic ctl_cas_a,
   input wire logic ctl_ras_a,
   input wire logic ctl_we_a,
   input wire logic [AW-1:0] ctl_addr_b,
   input wire logic ctl_cas_b,
   input wire logic ctl_ras_b,
   input wire logic ctl_we_b,
   input wire logic refresh_done_a,
   input wire logic refresh_done_b,
   output logic refresh_req_a,
   output logic refresh_req_b,
   // SDRAM pins
   output logic [AW-1:0] sdram_addr_a,
   output logic sdram_cas_a,
   output logic sdram_ras_a,
   output logic sdram_we_a,
   output logic [AW-1:0] sdram_addr_b,
   output logic sdram_cas_b,
   output logic sdram_ras_b,
   output logic sdram_we_b,
   output logic irq
);
   import sdo_pkg::*;

   // Registers
   logic [15:0] ctrl; // Enables; pulse bits never stored
   logic [15:0] refresh_cnt;
   logic [15:0] late_limit;
   logic [15:0] idle_addr;
   logic [15:0] man_addr;
   logic [15:0] cmd_levels;
   logic [1:0] late_stat; // Sticky lateness flags
   logic [1:0] int_mask;
   logic [1:0] man_pend; // One-cycle manual drive per bank

   // APB decode, byte address is four times the index
   // Register map notes:
   // Each register sits in the low half of one aligned word
   // Upper half of every word reads as zero
   // A stray low address bit makes the access unmapped
   // Unmapped writes are dropped; unknown indices read zero, unaligned reads return the register
   // The error flag is only raised in the access phase
   // Decode is purely combinational off the request signals
   wire [13:0] idx = paddr[15:2];
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire hit_ctrl = idx == 14'(IDX_CTRL);
   wire hit_cnt = idx == 14'(IDX_REFRESH_CNT);
   wire hit_lim = idx == 14'(IDX_LATE_LIMIT);
   wire hit_idle = idx == 14'(IDX_IDLE_ADDR);
   wire hit_man = idx == 14'(IDX_MAN_ADDR);
   wire hit_cmd = idx == 14'(IDX_CMD_LEVELS);
   wire hit_stat = idx == 14'(IDX_LATE_STAT);
   wire hit_mask = idx == 14'(IDX_INT_MASK);
   wire mapped = hit_ctrl | hit_cnt | hit_lim | hit_idle | hit_man | hit_cmd | hit_stat
                 | hit_mask;
   wire unmapped = !mapped || paddr[1:0] != 2'b00;

   // Enables and manual trigger
   // Manual trigger notes:
   // The trigger looks at the enable value being written
   // A write that enables a bank cannot also pulse it
   // Pulse bits are never stored, so they read back as zero
   // Both banks may be pulsed by one write
   wire en_a = ctrl[CTRL_EN_A];
   wire en_b = ctrl[CTRL_EN_B];
   wire [1:0] man_hit = {wr && !unmapped && hit_ctrl && pwdata[CTRL_MAN_B] && !pwdata[CTRL_EN_B],
                         wr && !unmapped && hit_ctrl && pwdata[CTRL_MAN_A] && !pwdata[CTRL_EN_A]};
   wire [1:0] late_ev;

   // Zero-wait answer
   assign pready = 1'b1;
   assign pslverr = access && unmapped;
   assign irq = |(late_stat & int_mask);

   // Register writes
   // Writes land at the access edge, psel and penable both high
   // Every field keeps its value until software writes it again
   // Bits above the address field are stored but never driven
   // Lateness limit and interval are shared by both banks
   // Mask holds one bit per bank, same layout as status
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ctrl <= RST_CTRL;
         refresh_cnt <= RST_REFRESH_CNT;
         late_limit <= RST_LATE_LIMIT;
         idle_addr <= RST_IDLE_ADDR;
         man_addr <= RST_MAN_ADDR;
         cmd_levels <= RST_CMD_LEVELS;
         int_mask <= 2'b00;
      end else if (wr && !unmapped) begin
         if (hit_ctrl) begin
            // Pulse bits self-clear, never stored
            ctrl <= pwdata[15:0] & ~(16'h0001 << CTRL_MAN_A) & ~(16'h0001 << CTRL_MAN_B);
         end
         if (hit_cnt) refresh_cnt <= pwdata[15:0];
         if (hit_lim) late_limit <= pwdata[15:0];
         if (hit_idle) idle_addr <= pwdata[15:0];
         if (hit_man) man_addr <= pwdata[15:0];
         if (hit_cmd) cmd_levels <= pwdata[15:0];
         if (hit_mask) int_mask <= pwdata[1:0];
      end
   end

   // Manual pulse lasts exactly one cycle
   // Pending flag is high in the cycle after the write edge
   // It drops on the next edge, so pins fall back to idle
   // A second pulse write may follow right away
   always_ff @(posedge mclk) begin
      if (!rstn) man_pend <= 2'b00;
      else man_pend <= man_hit;
   end

   // Sticky status, set wins over read clear
   // A lateness event in the clearing cycle is kept
   // Read data was latched in setup, so an event in the setup cycle is cleared unread
   always_ff @(posedge mclk) begin
      if (!rstn) late_stat <= 2'b00;
      else late_stat <= ((rd && hit_stat && !unmapped) ? 2'b00 : late_stat) | late_ev;
   end

   // Read data
   // Latched at the setup edge, valid through the access phase
   // Holds until the next read setup cycle
   // Status is captured here, then cleared at the access edge
   // Unknown indices read as zero
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (1'b1)
            hit_ctrl: prdata <= {16'h0000, ctrl};
            hit_cnt: prdata <= {16'h0000, refresh_cnt};
            hit_lim: prdata <= {16'h0000, late_limit};
            hit_idle: prdata <= {16'h0000, idle_addr};
            hit_man: prdata <= {16'h0000, man_addr};
            hit_cmd: prdata <= {16'h0000, cmd_levels};
            hit_stat: prdata <= {30'h0000_0000, late_stat};
            hit_mask: prdata <= {30'h0000_0000, int_mask};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Mode per bank
   // Enabled bank: normal controller owns the pins
   // Disabled bank: idle values, or manual values for one cycle
   // Enable wins over a pending manual cycle
   sdo_mode_t mode_a, mode_b;
   assign mode_a = en_a ? SDO_NORMAL : (man_pend[0] ? SDO_MANUAL : SDO_IDLE);
   assign mode_b = en_b ? SDO_NORMAL : (man_pend[1] ? SDO_MANUAL : SDO_IDLE);

   // Pin output notes:
   // Pins are a plain mux, no extra register stage
   // Idle levels follow register writes in the next cycle
   // Manual levels appear only while the pending flag is high
   // Command lines are taken bit by bit from the level register
   // Hazard: a register write during a manual cycle shows at once
   // Software should not rewrite levels while a pulse is pending
   // Pin select, bank A
   always_comb begin
      case (mode_a)
         SDO_NORMAL: begin
            sdram_addr_a = ctl_addr_a;
            {sdram_we_a, sdram_ras_a, sdram_cas_a} = {ctl_we_a, ctl_ras_a, ctl_cas_a};
         end
         SDO_MANUAL: begin
            sdram_addr_a = man_addr[AW-1:0];
            sdram_cas_a = cmd_levels[CMD_CAS_MAN];
            sdram_ras_a = cmd_levels[CMD_RAS_MAN];
            sdram_we_a = cmd_levels[CMD_WE_MAN];
         end
         default: begin
            sdram_addr_a = idle_addr[AW-1:0];
            sdram_cas_a = cmd_levels[CMD_CAS_IDLE];
            sdram_ras_a = cmd_levels[CMD_RAS_IDLE];
            sdram_we_a = cmd_levels[CMD_WE_IDLE];
         end
      endcase
   end

   // Pin select, bank B
   always_comb begin
      case (mode_b)
         SDO_NORMAL: begin
            sdram_addr_b = ctl_addr_b;
            {sdram_we_b, sdram_ras_b, sdram_cas_b} = {ctl_we_b, ctl_ras_b, ctl_cas_b};
         end
         SDO_MANUAL: begin
            sdram_addr_b = man_addr[AW-1:0];
            sdram_cas_b = cmd_levels[CMD_CAS_MAN];
            sdram_ras_b = cmd_levels[CMD_RAS_MAN];
            sdram_we_b = cmd_levels[CMD_WE_MAN];
         end
         default: begin
            sdram_addr_b = idle_addr[AW-1:0];
            sdram_cas_b = cmd_levels[CMD_CAS_IDLE];
            sdram_ras_b = cmd_levels[CMD_RAS_IDLE];
            sdram_we_b = cmd_levels[CMD_WE_IDLE];
         end
      endcase
   end

   // Refresh schedule and lateness, one per bank
   // Each checker runs only while its bank is enabled
   // Disabling a bank clears its owed count and report state
   // One error pulse per overrun, re-armed once owed falls back to the limit
   // Pulses set the sticky status bits above
   // Refresh request stays high while any refresh is owed
   // Normal controller answers with one done pulse per refresh
   sdo_refresh_check #(.CW(16)) u_chk_a (
      .mclk(mclk),
      .rstn(rstn),
      .run(en_a),
      .interval(refresh_cnt),
      .limit(late_limit),
      .refresh_done(refresh_done_a),
      .refresh_req(refresh_req_a),
      .late_error(late_ev[STAT_LATE_A])
   );

   sdo_refresh_check #(.CW(16)) u_chk_b (
      .mclk(mclk),
      .rstn(rstn),
      .run(en_b),
      .interval(refresh_cnt),
      .limit(late_limit),
      .refresh_done(refresh_done_b),
      .refresh_req(refresh_req_b),
      .late_error(late_ev[STAT_LATE_B])
   );
endmodule

`default_nettype wire

// File: tb/sdo_top_asserts.sv
// Purpose: Port checks for sdo_top, bank A pins and APB
// Assumes: shadows follow APB writes at the access edge
// Notes: bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module sdo_top_asserts #(
   parameter int AW = 14
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [AW-1:0] ctl_addr_a,
   input wire logic [AW-1:0] sdram_addr_a,
   input wire logic sdram_cas_a,
   input wire logic sdram_ras_a,
   input wire logic sdram_we_a
);
   logic [AW-1:0] idl; // Idle address shadow
   logic [AW-1:0] man; // Manual address shadow
   logic [5:0] cmd; // Line level shadow
   logic en; // Bank A enable shadow
   logic pul; // Manual cycle under way
   wire wr = psel && penable && pwrite;
   wire [2:0] lv = {sdram_we_a, sdram_ras_a, sdram_cas_a};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Shadows take writes at the access edge
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         idl <= '0;
         man <= '0;
         cmd <= 6'h3f;
         en <= 1'b0;
         pul <= 1'b0;
      end else begin
         if (wr && paddr == 16'h0958) idl <= pwdata[AW-1:0];
         if (wr && paddr == 16'h0960) man <= pwdata[AW-1:0];
         if (wr && paddr == 16'h0968) cmd <= pwdata[5:0];
         if (wr && paddr == 16'h0940) en <= pwdata[0];
         pul <= wr && paddr == 16'h0940 && pwdata[2] && !pwdata[0];
      end
   end
   pready_on_a: assert property (pready) else $error("pready low");
   unaligned_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("no error on unaligned access");
   unmapped_zero_a: assert property (psel && penable && !pwrite && paddr == 16'h0004
      |-> pslverr && prdata == '0) else $error("unmapped read wrong");
   idle_addr_a: assert property (!en && !pul |-> sdram_addr_a == idl)
      else $error("idle address wrong");
   idle_cmd_a: assert property (!en && !pul |-> lv == cmd[2:0])
      else $error("idle levels wrong");
   man_addr_a: assert property (pul |-> sdram_addr_a == man)
      else $error("manual address wrong");
   man_cmd_a: assert property (pul |-> lv == cmd[5:3])
      else $error("manual levels wrong");
   pass_a: assert property (en |-> sdram_addr_a == ctl_addr_a)
      else $error("enabled bank not passed");
endmodule
bind sdo_top sdo_top_asserts #(.AW(AW)) chk_u (
   .mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .ctl_addr_a, .sdram_addr_a, .sdram_cas_a, .sdram_ras_a, .sdram_we_a
);
`default_nettype wire

// File: tb/sdo_sdram_model.sv
// Purpose: Far side and normal controller stand-in, both banks
// Assumes: one refresh paid per two cycles unless stalled
// Notes: controller levels move every cycle so stale pins show
`timescale 1ns/10ps
`default_nettype none
module sdo_sdram_model (
   input wire logic mclk,
   input wire logic [1:0] stall,
   input wire logic [1:0] refresh_req,
   output logic [1:0] refresh_done,
   output logic [13:0] ctl_addr,
   output logic [2:0] ctl_cmd
);
   initial begin
      refresh_done = 2'h0;
      ctl_addr = 14'h0000;
      ctl_cmd = 3'h0;
   end
   // Pays owed refreshes, changing levels each cycle
   always @(posedge mclk) begin
      refresh_done <= refresh_req & ~stall & ~refresh_done;
      ctl_addr <= ctl_addr + 14'h1357;
      ctl_cmd <= ctl_cmd + 3'h1;
   end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for sdo_top
// Assumes: zero-wait APB, far side in sdo_sdram_model
// Notes: refresh interval cut short by register write
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sdo_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic err;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] rd;
   logic [1:0] stall = 2'h0;
   wire [31:0] prdata;
   wire pready, pslverr, irq;
   wire [1:0] req, done;
   wire [13:0] caddr, sa_a, sa_b;
   wire [2:0] ccmd, sc_a, sc_b;
   int r [8]; // Expected register words
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n;
   sdo_top dut_u (
      .mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ctl_addr_a(caddr), .ctl_cas_a(ccmd[0]), .ctl_ras_a(ccmd[1]), .ctl_we_a(ccmd[2]),
      .ctl_addr_b(caddr), .ctl_cas_b(ccmd[0]), .ctl_ras_b(ccmd[1]), .ctl_we_b(ccmd[2]),
      .refresh_done_a(done[0]), .refresh_done_b(done[1]), .refresh_req_a(req[0]),
      .refresh_req_b(req[1]), .sdram_addr_a(sa_a), .sdram_cas_a(sc_a[0]), .irq,
      .sdram_ras_a(sc_a[1]), .sdram_we_a(sc_a[2]), .sdram_addr_b(sa_b),
      .sdram_cas_b(sc_b[0]), .sdram_ras_b(sc_b[1]), .sdram_we_b(sc_b[2]));
   sdo_sdram_model far_u (.mclk, .stall, .refresh_req(req), .refresh_done(done),
      .ctl_addr(caddr), .ctl_cmd(ccmd));
   always #4 mclk = ~mclk;
   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1 && cyc < 3000);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input int i, input int d);
      apb(1'b1, 16'(IDX_CTRL * 4 + 8 * i), 32'(d));
      r[i] = d & (i == 0 ? 32'h0000_fff3 : 32'h0000_ffff);
   endtask
   task automatic rdchk(input int i);
      apb(1'b0, 16'(IDX_CTRL * 4 + 8 * i), 32'h0000_0000);
      chk("register", rd, 32'(r[i]));
   endtask
   function automatic logic [31:0] ex(input logic m);
      return m ? 32'({r[5][5:3], r[4][13:0]}) : 32'({r[5][2:0], r[3][13:0]});
   endfunction
   // Pin levels of both banks, m marks a manual cycle
   task automatic pins(input logic [1:0] m);
      #1;
      chk("pins a", 32'({sc_a, sa_a}), ex(m[0]));
      chk("pins b", 32'({sc_b, sa_b}), ex(m[1]));
   endtask
   task automatic wt(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge mclk);
         n++;
      end
   endtask
   initial begin
      n = $urandom(32'h0241_3e79);
      r = '{RST_CTRL, RST_REFRESH_CNT, RST_LATE_LIMIT, RST_IDLE_ADDR,
         RST_MAN_ADDR, RST_CMD_LEVELS, 0, 0};
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) rdchk(i);
      pins(2'h0);
      apb(1'b0, 16'h0004, 32'h0000_0000);
      chk("unmapped", {rd[31:1], err}, 32'h0000_0001);
      apb(1'b1, 16'h0942, 32'h0000_ffff);
      chk("unaligned", 32'(err), 32'h0000_0001);
      rdchk(0);
      $display("test reset done");
      for (int i = 3; i < 6; i++) wr(i, $urandom & (i == 5 ? 32'h003f : 32'h3fff));
      for (int i = 3; i < 6; i++) rdchk(i);
      pins(2'h0);
      for (int b = 0; b < 2; b++) begin
         wr(0, 4 << b);
         pins(2'(1 << b));
         @(posedge mclk);
         pins(2'h0);
         rdchk(0);
      end
      wr(0, 5);
      #1 chk("pass a", 32'({sc_a, sa_a}), 32'({ccmd, caddr}));
      chk("idle b", 32'({sc_b, sa_b}), ex(1'b0));
      $display("test pins done");
      wr(0, 0);
      stall <= 2'h3;
      wr(1, 8);
      wr(2, 2);
      wr(7, 1);
      wr(0, 2);
      wt(40);
      chk("masked irq", 32'(irq), 32'h0000_0000);
      r[6] = 2;
      rdchk(6);
      r[6] = 0;
      wr(0, 3);
      wt(60);
      chk("late time", 32'(n >= 16 && n <= 32), 32'h0000_0001);
      chk("refresh req", 32'(req[0]), 32'h0000_0001);
      r[6] = 1;
      rdchk(6);
      r[6] = 0;
      #1 chk("irq cleared", 32'(irq), 32'h0000_0000);
      $display("test refresh done");
      close_out();
   end
endmodule
`default_nettype wire
